// [hw/hrs_regs.vh]
// Constants for the hot reset sequencer
`ifndef HRS_REGS_VH
`define HRS_REGS_VH
`define HRS_CLK_MHZ 40
`define HRS_TRAIN_LIMIT_US 20000
`define HRS_CFG_LIMIT_US 100000
`define HRS_TRAIN_CYCLES (`HRS_TRAIN_LIMIT_US * `HRS_CLK_MHZ)
`define HRS_CFG_CYCLES (`HRS_CFG_LIMIT_US * `HRS_CLK_MHZ)
`define HRS_ST_IDLE 3'h0
`define HRS_ST_CPL 3'h1
`define HRS_ST_RESET 3'h2
`define HRS_ST_QUASI 3'h3
`define HRS_ST_LOAD 3'h4
`define HRS_ST_HALT 3'h5
`define HRS_ST_RUN 3'h6
`define HRS_ERR_W 4
`define HRS_ERR_RST 4'h0
`endif

// [hw/hrs_sequencer.v]
// Hot reset sequencer of the switch
`timescale 1ns/1ps
`include "hrs_regs.vh"
module hrs_sequencer #(
   parameter NPORTS = 3,
   parameter TRAIN_CYCLES = `HRS_TRAIN_CYCLES,
   parameter CFG_CYCLES = `HRS_CFG_CYCLES
) (
   // Clock, enable and reset
   input wire clk,
   input wire ce,
   input wire rst_n,
   // Triggers
   input wire ts1_hot_reset_rx,
   input wire dl_down,
   input wire hot_reset_request_bit,
   input wire secondary_bus_reset_bit,
   input wire link_down_hot_reset_disable,
   input wire cfg_write_done,
   // Configuration
   input wire eeprom_mode,
   input wire skip_eeprom_on_hot_reset,
   input wire halt_clear,
   // Downstream link state
   input wire [NPORTS-1:0] ds_link_up,
   // EEPROM loader
   input wire load_done,
   input wire load_error,
   input wire [`HRS_ERR_W-1:0] load_error_code,
   input wire [NPORTS-1:0] load_retrain_wr,
   // Sequencer outputs
   output reg [NPORTS-1:0] ds_send_hot_reset_ts1,
   output reg core_reset,
   output reg nonsticky_reset,
   output reg train_start,
   output reg quasi_reset,
   output reg cfg_retry_enable,
   output reg drop_other_tlp,
   output reg load_start,
   output reg load_abort,
   output reg [NPORTS-1:0] retrain_port,
   output reg reset_halt_bit,
   output reg load_complete,
   output reg [`HRS_ERR_W-1:0] smbus_error,
   output reg cpl_release,
   output reg train_late,
   output reg normal_run,
   output reg [2:0] state
);

   ////////////////////////////////////////////////////////////////////////////
   // The four trigger inputs ts1, dl_down, request and bus reset pass two flops first
   wire [3:0] trig_s;
   hrs_sync #(.WIDTH(4)) u_sync (
      .clk(clk),
      .ce(ce),
      .d({ts1_hot_reset_rx, dl_down, hot_reset_request_bit, secondary_bus_reset_bit}),
      .q(trig_s)
   );

   wire ts1_s = trig_s[3];
   wire dl_s = trig_s[2];
   wire req_s = trig_s[1];
   wire sbr_s = trig_s[0];

   ////////////////////////////////////////////////////////////////////////////
   // Trigger detection
   reg dl_prev;
   reg req_prev;
   reg sbr_prev;
   wire dl_edge = dl_s & ~dl_prev & ~link_down_hot_reset_disable;
   wire req_edge = req_s & ~req_prev;
   wire sbr_edge = sbr_s & ~sbr_prev;
   wire trig_edge = (ts1_s | dl_edge | sbr_edge);
   // Condition is still present while any synced trigger level stands, dl_down only while link_down_hot_reset_disable is low
   wire trig_active = ts1_s | (dl_s & ~link_down_hot_reset_disable) | sbr_s | req_s;

   reg [31:0] timer;
   reg [2:0] next_state;

   ////////////////////////////////////////////////////////////////////////////
   // Next state, decoded once so entry actions can see the change early
   always @* begin
      next_state = state;
      case (state)
         `HRS_ST_IDLE, `HRS_ST_RUN: begin
            if (req_edge) begin
               next_state = `HRS_ST_CPL;
            end else if (trig_edge) begin
               next_state = `HRS_ST_RESET;
            end
         end
         `HRS_ST_CPL: begin
            if (cfg_write_done) begin
               next_state = `HRS_ST_RESET;
            end
         end
         `HRS_ST_RESET: begin
            if (!trig_active) begin
               next_state = `HRS_ST_QUASI;
            end
         end
         `HRS_ST_QUASI: begin
            if (eeprom_mode && !skip_eeprom_on_hot_reset) begin
               next_state = `HRS_ST_LOAD;
            end else begin
               next_state = `HRS_ST_RUN;
            end
         end
         `HRS_ST_LOAD: begin
            if (load_error) begin
               next_state = `HRS_ST_HALT;
            end else if (load_done) begin
               next_state = `HRS_ST_RUN;
            end
         end
         `HRS_ST_HALT: begin
            if (halt_clear) begin
               next_state = `HRS_ST_RUN;
            end
         end
         default: begin
            next_state = `HRS_ST_IDLE;
         end
      endcase
   end

   // Entry into the reset step, so its outputs rise with the state
   wire enter_reset = (state != `HRS_ST_RESET) && (next_state == `HRS_ST_RESET);
   // Still inside the reset step on the next cycle
   wire hold_reset = (state == `HRS_ST_RESET) && trig_active;
   wire in_wait = (state == `HRS_ST_QUASI) || (state == `HRS_ST_LOAD);

   ////////////////////////////////////////////////////////////////////////////
   // Edge history of the synced dl_down, request and bus reset triggers
   always @(posedge clk) begin
      if (!rst_n) begin
         dl_prev <= 1'b0;
         req_prev <= 1'b0;
         sbr_prev <= 1'b0;
      end else if (ce) begin
         dl_prev <= dl_s;
         req_prev <= req_s;
         sbr_prev <= sbr_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Training watchdog; it only counts once the condition has cleared
   always @(posedge clk) begin
      if (!rst_n) begin
         timer <= 32'h00000000;
         train_late <= 1'b0;
      end else if (ce) begin
         if (enter_reset || hold_reset) begin
            timer <= 32'h00000000;
         end else if (in_wait) begin
            timer <= timer + 32'h00000001;
            if (timer >= (TRAIN_CYCLES - 1)) begin
               train_late <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-port forwarding and retrain strobes
   genvar gi;
   generate
      for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_port
         always @(posedge clk) begin
            if (!rst_n) begin
               ds_send_hot_reset_ts1[gi] <= 1'b0;
               retrain_port[gi] <= 1'b0;
            end else if (ce) begin
               // A port whose link is down has nobody to forward to
               if (enter_reset || hold_reset) begin
                  ds_send_hot_reset_ts1[gi] <= ds_link_up[gi];
               end else begin
                  ds_send_hot_reset_ts1[gi] <= 1'b0;
               end
               retrain_port[gi] <= (state == `HRS_ST_LOAD) & load_retrain_wr[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always @(posedge clk) begin
      if (!rst_n) begin
         state <= `HRS_ST_IDLE;
         core_reset <= 1'b0;
         nonsticky_reset <= 1'b0;
         train_start <= 1'b0;
         quasi_reset <= 1'b0;
         cfg_retry_enable <= 1'b0;
         drop_other_tlp <= 1'b0;
         load_start <= 1'b0;
         load_abort <= 1'b0;
         reset_halt_bit <= 1'b0;
         load_complete <= 1'b0;
         smbus_error <= `HRS_ERR_RST;
         cpl_release <= 1'b0;
         normal_run <= 1'b1;
      end else if (ce) begin
         train_start <= 1'b0;
         load_start <= 1'b0;
         load_abort <= 1'b0;
         cpl_release <= 1'b0;
         nonsticky_reset <= 1'b0;
         // Entry actions land with the state change, not a cycle later
         if (enter_reset) begin
            core_reset <= 1'b1;
            nonsticky_reset <= 1'b1;
            normal_run <= 1'b0;
            load_complete <= 1'b0;
         end
         case (state)
            `HRS_ST_IDLE, `HRS_ST_RUN: begin
               if (req_edge) begin
                  // Completion must leave before the reset clears the stack
                  state <= `HRS_ST_CPL;
               end else if (trig_edge) begin
                  state <= `HRS_ST_RESET;
               end
            end
            `HRS_ST_CPL: begin
               if (cfg_write_done) begin
                  state <= `HRS_ST_RESET;
               end else begin
                  // Completion stands until the write is known to be answered
                  cpl_release <= 1'b1;
               end
            end
            `HRS_ST_RESET: begin
               normal_run <= 1'b0;
               core_reset <= 1'b1;
               nonsticky_reset <= 1'b1;
               load_complete <= 1'b0;
               if (!trig_active) begin
                  core_reset <= 1'b0;
                  train_start <= 1'b1;
                  quasi_reset <= 1'b1;
                  // Retry must already stand in the first quasi-reset cycle
                  cfg_retry_enable <= 1'b1;
                  drop_other_tlp <= 1'b1;
                  state <= `HRS_ST_QUASI;
               end
            end
            `HRS_ST_QUASI: begin
               cfg_retry_enable <= 1'b1;
               drop_other_tlp <= 1'b1;
               if (eeprom_mode && !skip_eeprom_on_hot_reset) begin
                  load_start <= 1'b1;
                  state <= `HRS_ST_LOAD;
               end else begin
                  state <= `HRS_ST_RUN;
                  quasi_reset <= 1'b0;
                  cfg_retry_enable <= 1'b0;
                  drop_other_tlp <= 1'b0;
                  normal_run <= 1'b1;
               end
            end
            `HRS_ST_LOAD: begin
               if (load_error) begin
                  load_abort <= 1'b1;
                  reset_halt_bit <= 1'b1;
                  smbus_error <= load_error_code;
                  load_complete <= 1'b1;
                  core_reset <= 1'b1;
                  state <= `HRS_ST_HALT;
               end else if (load_done) begin
                  load_complete <= 1'b1;
                  quasi_reset <= 1'b0;
                  cfg_retry_enable <= 1'b0;
                  drop_other_tlp <= 1'b0;
                  normal_run <= 1'b1;
                  state <= `HRS_ST_RUN;
               end
            end
            `HRS_ST_HALT: begin
               // Quasi-reset stays so config requests still see retry
               if (halt_clear) begin
                  reset_halt_bit <= 1'b0;
                  core_reset <= 1'b0;
                  quasi_reset <= 1'b0;
                  cfg_retry_enable <= 1'b0;
                  drop_other_tlp <= 1'b0;
                  normal_run <= 1'b1;
                  state <= `HRS_ST_RUN;
               end
            end
            default: begin
               state <= `HRS_ST_IDLE;
            end
         endcase
      end
   end

endmodule

// [hw/hrs_sync.v]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module hrs_sync #(
   parameter WIDTH = 4
) (
   // Clock
   input wire clk,
   input wire ce,
   // Data
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta;
   always @(posedge clk) begin
      if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// [verification/hrs_loader_model.sv]
// Behavioural serial EEPROM loader facing the sequencer
`timescale 1ns/1ps
module hrs_loader_model (
   // Control
   input logic clk, rst_n, load_start, fail,
   // Answers
   output logic load_done, load_error,
   output logic [3:0] load_error_code,
   output logic [2:0] load_retrain_wr
);
   int cnt;
   always @(posedge clk) begin
      load_done <= 1'b0;
      load_error <= 1'b0;
      load_retrain_wr <= 3'h0;
      load_error_code <= fail ? 4'hA : 4'h0;
      if (!rst_n)
         cnt <= 0;
      else if (load_start)
         cnt <= 6;
      else if (cnt != 0) begin
         cnt <= cnt - 1;
         // Retrain write lands mid-image, as a real load would apply it
         if (cnt == 3)
            load_retrain_wr <= 3'h2;
         if (cnt == 1) begin
            load_done <= !fail;
            load_error <= fail;
         end
      end
   end
endmodule

// [verification/hrs_properties.sv]
// Port checks of the hot reset sequencer
`timescale 1ns/1ps
`include "hrs_regs.vh"
module hrs_properties (
   // Clock, reset and inputs
   input logic clk, rst_n, cfg_write_done, eeprom_mode, skip_eeprom_on_hot_reset, load_error,
   input logic [2:0] ds_link_up, load_retrain_wr,
   // Outputs
   input logic core_reset, train_start, quasi_reset, cfg_retry_enable, drop_other_tlp,
   input logic load_start, reset_halt_bit, load_complete, normal_run, cpl_release,
   input logic [2:0] ds_send_hot_reset_ts1, retrain_port, state
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ts1_fwd: assert property (state == `HRS_ST_RESET |-> ds_send_hot_reset_ts1 == $past(ds_link_up))
      else $error("ts1 forward");
   a_train_once: assert property (train_start |-> quasi_reset && $past(core_reset) ##1 !train_start)
      else $error("train pulse");
   a_retry_quasi: assert property (quasi_reset |-> cfg_retry_enable && drop_other_tlp)
      else $error("retry in quasi");
   a_load_gate: assert property (load_start |-> eeprom_mode && !skip_eeprom_on_hot_reset)
      else $error("load gate");
   a_retrain_copy: assert property (retrain_port != 0 |-> retrain_port == $past(load_retrain_wr))
      else $error("retrain copy");
   a_halt_cause: assert property ($rose(reset_halt_bit) |-> $past(load_error) && load_complete)
      else $error("halt cause");
   a_halt_hold: assert property (reset_halt_bit |-> core_reset && !normal_run)
      else $error("halt hold");
   a_run_clean: assert property (normal_run |-> !quasi_reset && !core_reset)
      else $error("run clean");
   a_cpl_first: assert property ($fell(cpl_release) |-> core_reset && $past(cfg_write_done))
      else $error("cpl order");
   c_train: cover property (train_start);
   c_halt: cover property ($rose(reset_halt_bit));
   c_cpl: cover property ($fell(cpl_release));
endmodule
////////////////////////////////////////////////////////////////////////////////
bind hrs_sequencer hrs_properties u_chk (.clk, .rst_n, .cfg_write_done, .eeprom_mode,
   .skip_eeprom_on_hot_reset, .load_error, .ds_link_up, .load_retrain_wr, .core_reset,
   .train_start, .quasi_reset, .cfg_retry_enable, .drop_other_tlp, .load_start,
   .reset_halt_bit, .load_complete, .normal_run, .cpl_release, .ds_send_hot_reset_ts1,
   .retrain_port, .state);

// [verification/hrs_sequencer_tb_top.sv]
// Self-checking bench for the hot reset sequencer
`timescale 1ns/1ps
`include "hrs_regs.vh"
module hrs_sequencer_tb_top;
   logic clk = 0, rst_n = 0, fail = 0, cwd = 0, hclr = 0, dis = 0, skip = 0;
   logic [3:0] trg = 4'h0;
   logic load_done, load_error, core_reset, train_start, cfg_retry_enable, load_start;
   logic reset_halt_bit, load_complete, cpl_release, train_late, normal_run;
   logic nonsticky_reset, load_abort;
   logic [2:0] lwr, ts1, state;
   logic [3:0] code, smbus_error;
   int errors = 0, total_checks = 0, cycles = 0;
   always #12.5 clk = ~clk;
   hrs_sequencer #(.TRAIN_CYCLES(20), .CFG_CYCLES(100)) dut (.clk, .ce(1'b1), .rst_n,
      .ts1_hot_reset_rx(trg[0]), .dl_down(trg[1]), .hot_reset_request_bit(trg[2]),
      .secondary_bus_reset_bit(trg[3]), .link_down_hot_reset_disable(dis),
      .cfg_write_done(cwd), .eeprom_mode(1'b1), .skip_eeprom_on_hot_reset(skip),
      .halt_clear(hclr), .ds_link_up(3'h5), .load_done, .load_error, .load_error_code(code),
      .load_retrain_wr(lwr), .ds_send_hot_reset_ts1(ts1), .core_reset, .nonsticky_reset,
      .train_start, .quasi_reset(), .cfg_retry_enable, .drop_other_tlp(), .load_start,
      .load_abort, .retrain_port(), .reset_halt_bit, .load_complete, .smbus_error,
      .cpl_release, .train_late, .normal_run, .state);
   hrs_loader_model u_ld (.clk, .rst_n, .load_start, .fail, .load_done, .load_error,
      .load_error_code(code), .load_retrain_wr(lwr));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         final_report;
      end
   end
   task automatic chk(input string w, input logic [3:0] e, g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s exp %0h got %0h", w, e, g);
      end
   endtask
   task automatic chk_bit(input string w, input logic e, g);
      chk(w, {3'h0, e}, {3'h0, g});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait, so a stuck sequencer shows as a mismatch
   task automatic wait_st(input logic [2:0] s);
      for (int i = 0; i < 200 && state !== s; i++) @(negedge clk);
      chk("state", {1'b0, s}, {1'b0, state});
   endtask
   task automatic hit(input int b);
      trg[b] = 1'b1;
      cyc(4);
      trg[b] = 1'b0;
   endtask
   task automatic quasi;
      wait_st(`HRS_ST_RESET);
      chk("ts1", 4'h5, {1'b0, ts1});
      chk_bit("core", 1'b1, core_reset);
      chk_bit("nonsticky", 1'b1, nonsticky_reset);
      wait_st(`HRS_ST_QUASI);
      chk_bit("train", 1'b1, train_start);
      chk_bit("retry", 1'b1, cfg_retry_enable);
   endtask
   task automatic t_load;
      hit(0);
      quasi;
      wait_st(`HRS_ST_LOAD);
      wait_st(`HRS_ST_RUN);
      chk_bit("done", 1'b1, load_complete);
      chk_bit("late", 1'b0, train_late);
      chk_bit("halt", 1'b0, reset_halt_bit);
      $display("test load done");
   endtask
   task automatic t_down;
      dis = 1'b1;
      hit(1);
      cyc(4);
      chk("state", {1'b0, `HRS_ST_RUN}, {1'b0, state});
      dis = 1'b0;
      skip = 1'b1;
      hit(1);
      quasi;
      cyc(1);
      chk("state", {1'b0, `HRS_ST_RUN}, {1'b0, state});
      skip = 1'b0;
      hit(3);
      quasi;
      wait_st(`HRS_ST_RUN);
      $display("test down done");
   endtask
   task automatic t_req;
      trg[2] = 1'b1;
      wait_st(`HRS_ST_CPL);
      cyc(5);
      chk_bit("early", 1'b0, core_reset);
      chk_bit("cpl", 1'b1, cpl_release);
      cwd = 1'b1;
      cyc(1);
      cwd = 1'b0;
      trg[2] = 1'b0;
      quasi;
      wait_st(`HRS_ST_RUN);
      $display("test req done");
   endtask
   task automatic t_err;
      fail = 1'b1;
      hit(0);
      quasi;
      wait_st(`HRS_ST_HALT);
      chk_bit("halt", 1'b1, reset_halt_bit);
      chk_bit("abort", 1'b1, load_abort);
      chk_bit("done", 1'b1, load_complete);
      chk("code", 4'hA, smbus_error);
      cyc(5);
      chk_bit("hold", 1'b1, core_reset);
      hclr = 1'b1;
      cyc(1);
      hclr = 1'b0;
      fail = 1'b0;
      wait_st(`HRS_ST_RUN);
      $display("test err done");
   endtask
   initial begin
      cyc(12);
      rst_n = 1'b1;
      wait_st(`HRS_ST_IDLE);
      t_load;
      t_down;
      t_req;
      t_err;
      final_report;
   end
endmodule
